// >>> common/dsp_ext_pkg.sv
package dsp_ext_pkg;
  localparam int WORD_W   = 32;
  localparam int HALF_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int ACC_W    = 64;
  localparam int ACC_N    = 4;
  localparam int ACC_IX_W = 2;
  localparam int IMM_W    = 10;
  localparam int FSIZE_LO = 10;
  localparam int FSIZE_HI = 14;
  localparam int FPOS_LO  = 16;
  localparam int FPOS_HI  = 20;
  localparam int ROUND_BIT = 31;
  localparam logic [15:0] Q15_MIN = 16'h8000;
  localparam logic [15:0] Q15_MAX = 16'h7FFF;
  localparam logic [31:0] Q31_MIN = 32'h80000000;
  localparam logic [31:0] Q31_MAX = 32'h7FFFFFFF;
  localparam logic [63:0] ACC_RESET = 64'h0000000000000000;

  typedef enum logic [3:0] {
    OP_PAIR_FRAC_MUL_SAT,
    OP_WORD_FRAC_MUL_SAT,
    OP_WORD_FRAC_MUL_ROUND,
    OP_HALF_DIFF_ACC,
    OP_SIGNED_MUL_ADD,
    OP_UNSIGNED_MUL_ADD,
    OP_SIGNED_MUL_SUB,
    OP_UNSIGNED_MUL_SUB,
    OP_SIGNED_PRODUCT,
    OP_UNSIGNED_PRODUCT,
    OP_LOW_HALF_MIRROR,
    OP_FIELD_INSERT_CTRL,
    OP_BYTE_REPL_LIT,
    OP_BYTE_REPL_REG,
    OP_HALF_REPL_LIT,
    OP_HALF_REPL_REG
  } dsp_op_t;
endpackage

// >>> core/dsp_bit_ops.sv
`timescale 1ns/1ps
module dsp_bit_ops
  import dsp_ext_pkg::*;
(
  input  wire dsp_op_t          op,          // Decoded operation
  input  wire logic [31:0]      src_one,     // First source word
  input  wire logic [31:0]      src_two,     // Second source word
  input  wire logic [IMM_W-1:0] imm,         // Immediate
  input  wire logic [31:0]      ctrl_word,   // Signal processing control word
  output logic      [31:0]      bit_result   // Combinational result
);
  logic [4:0]  fsize;
  logic [4:0]  fpos;
  logic [31:0] mask;
  logic [31:0] mirror;
  logic [15:0] half_lit;

  assign fsize = ctrl_word[FSIZE_HI:FSIZE_LO];
  assign fpos  = ctrl_word[FPOS_HI:FPOS_LO];
  // Zero size leaves the destination untouched
  assign mask  = ((32'h1 << fsize) - 32'h1) << fpos;
  assign half_lit = {{(HALF_W-IMM_W){imm[IMM_W-1]}}, imm};

  genvar i;
  generate
    for (i = 0; i < HALF_W; i++) begin : g_mirror
      assign mirror[i] = src_two[HALF_W-1-i];
    end
  endgenerate
  assign mirror[31:HALF_W] = 16'h0000;

  always_comb begin
    unique case (op)
      OP_LOW_HALF_MIRROR:   bit_result = mirror;
      OP_FIELD_INSERT_CTRL: bit_result = (src_two & ~mask) | ((src_one << fpos) & mask);
      OP_BYTE_REPL_LIT:     bit_result = {4{imm[BYTE_W-1:0]}};
      OP_BYTE_REPL_REG:     bit_result = {4{src_two[BYTE_W-1:0]}};
      OP_HALF_REPL_LIT:     bit_result = {2{half_lit}};
      OP_HALF_REPL_REG:     bit_result = {2{src_two[HALF_W-1:0]}};
      default:              bit_result = 32'h00000000;
    endcase
  end
endmodule

// >>> core/dsp_fraction_multiply_bit_ops.sv
`timescale 1ns/1ps
// Summary of operation
// - Paired Q15 multiply, upper product halves
// - Paired element minus-one squared saturates
// - Word Q31 multiply keeps upper half
// - Word minus-one squared gives max Q31
// - Rounding multiply adds bit 31 first
// - Rounding minus-one case skips round, saturates
// - Halfword products: left minus right, accumulate
// - Word multiplies target any of four accumulators
// - Mirror low sixteen bits, zero upper
// - Insert field using control size and position
// - Replicate low byte into four lanes
// - Replicate halfword, immediate sign-extended
module dsp_fraction_multiply_bit_ops
  import dsp_ext_pkg::*;
#(
  parameter int ACC_COUNT = ACC_N
)(
  input  wire logic                clk_sys,     // 100 MHz core clock
  input  wire logic                rst,         // Async reset, active high
  input  wire logic                issue,       // Operation valid this cycle
  input  wire dsp_op_t             op,          // Decoded operation
  input  wire logic [31:0]         src_one,     // First source word
  input  wire logic [31:0]         src_two,     // Second source word
  input  wire logic [IMM_W-1:0]    imm,         // Immediate
  input  wire logic [ACC_IX_W-1:0] acc_sel,     // Accumulator index
  input  wire logic [4:0]          dest_ix,     // Destination register index
  input  wire logic [31:0]         ctrl_word,   // Signal processing control word
  output logic                     gpr_we,      // Register result valid
  output logic [4:0]               gpr_ix,      // Register result index
  output logic [31:0]              gpr_data,    // Register result
  output logic                     acc_we,      // Accumulator updated
  output logic [ACC_IX_W-1:0]      acc_ix,      // Accumulator index written
  output logic [ACC_W-1:0]         acc_data     // New accumulator value
);
  logic [ACC_W-1:0] acc_reg [ACC_COUNT];
  logic [ACC_W-1:0] acc_next;
  logic [31:0]      reg_next;
  logic [31:0]      bit_result;
  logic             is_acc_op;
  logic             is_reg_op;

  logic signed [31:0] ph_hi_prod;
  logic signed [31:0] ph_lo_prod;
  logic [15:0]        ph_hi;
  logic [15:0]        ph_lo;
  logic signed [63:0] w_prod;
  logic [63:0]        w_round;
  logic               w_both_min;
  logic signed [31:0] h_left;
  logic signed [31:0] h_right;
  logic signed [63:0] h_diff;
  logic signed [63:0] s_prod;
  logic [63:0]        u_prod;
  logic [ACC_W-1:0]   acc_cur;

  dsp_bit_ops u_bit_ops (
    .op         (op),
    .src_one    (src_one),
    .src_two    (src_two),
    .imm        (imm),
    .ctrl_word  (ctrl_word),
    .bit_result (bit_result)
  );

  // Fractional products are doubled: shift left one after integer multiply
  assign ph_hi_prod = $signed(src_one[31:16]) * $signed(src_two[31:16]);
  assign ph_lo_prod = $signed(src_one[15:0]) * $signed(src_two[15:0]);
  assign ph_hi = (src_one[31:16] == Q15_MIN && src_two[31:16] == Q15_MIN)
               ? Q15_MAX : ph_hi_prod[30:15];
  assign ph_lo = (src_one[15:0] == Q15_MIN && src_two[15:0] == Q15_MIN)
               ? Q15_MAX : ph_lo_prod[30:15];

  assign w_prod     = $signed(src_one) * $signed(src_two);
  assign w_both_min = (src_one == Q31_MIN) && (src_two == Q31_MIN);
  assign w_round    = {w_prod[62:0], 1'b0} + (64'h1 << ROUND_BIT);

  assign h_left  = $signed(src_one[31:16]) * $signed(src_two[31:16]);
  assign h_right = $signed(src_one[15:0]) * $signed(src_two[15:0]);
  assign h_diff  = 64'(h_left) - 64'(h_right);

  assign s_prod = $signed(src_one) * $signed(src_two);
  assign u_prod = src_one * src_two;
  assign acc_cur = acc_reg[acc_sel];

  always_comb begin
    is_reg_op = 1'b1;
    reg_next  = bit_result;
    unique case (op)
      OP_PAIR_FRAC_MUL_SAT:   reg_next = {ph_hi, ph_lo};
      OP_WORD_FRAC_MUL_SAT:   reg_next = w_both_min ? Q31_MAX : w_prod[62:31];
      OP_WORD_FRAC_MUL_ROUND: reg_next = w_both_min ? Q31_MAX : w_round[63:32];
      OP_HALF_DIFF_ACC, OP_SIGNED_MUL_ADD, OP_UNSIGNED_MUL_ADD, OP_SIGNED_MUL_SUB,
      OP_UNSIGNED_MUL_SUB, OP_SIGNED_PRODUCT, OP_UNSIGNED_PRODUCT: is_reg_op = 1'b0;
      default: reg_next = bit_result;
    endcase
  end

  assign is_acc_op = !is_reg_op;

  always_comb begin
    acc_next = acc_cur;
    unique case (op)
      OP_HALF_DIFF_ACC:    acc_next = acc_cur + h_diff;
      OP_SIGNED_MUL_ADD:   acc_next = acc_cur + s_prod;
      OP_UNSIGNED_MUL_ADD: acc_next = acc_cur + u_prod;
      OP_SIGNED_MUL_SUB:   acc_next = acc_cur - s_prod;
      OP_UNSIGNED_MUL_SUB: acc_next = acc_cur - u_prod;
      OP_SIGNED_PRODUCT:   acc_next = s_prod;
      OP_UNSIGNED_PRODUCT: acc_next = u_prod;
      default:             acc_next = acc_cur;
    endcase
  end

  // Accumulators live here so multiply-add chains need no read-back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < ACC_COUNT; k++) begin
        acc_reg[k] <= ACC_RESET;
      end
    end else if (issue && is_acc_op) begin
      acc_reg[acc_sel] <= acc_next;
    end
  end

  // Result presented one cycle after issue; host must take it then
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gpr_we   <= 1'b0;
      gpr_ix   <= 5'h00;
      gpr_data <= 32'h00000000;
    end else begin
      gpr_we <= issue && is_reg_op;
      if (issue && is_reg_op) begin
        gpr_ix   <= dest_ix;
        gpr_data <= reg_next;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_we   <= 1'b0;
      acc_ix   <= 2'h0;
      acc_data <= ACC_RESET;
    end else begin
      acc_we <= issue && is_acc_op;
      if (issue && is_acc_op) begin
        acc_ix   <= acc_sel;
        acc_data <= acc_next;
      end
    end
  end

  pair_sat_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_PAIR_FRAC_MUL_SAT && src_one[15:0] == Q15_MIN && src_two[15:0] == Q15_MIN
    |=> gpr_we && gpr_data[15:0] == Q15_MAX)
    else $error("paired saturation missing");
  pair_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_PAIR_FRAC_MUL_SAT && src_one[31:16] == 16'h4000
    && src_two[31:16] == 16'h4000 |=> gpr_data[31:16] == 16'h2000)
    else $error("paired product wrong");
  word_trunc_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_WORD_FRAC_MUL_SAT && !w_both_min |=> gpr_data == $past(w_prod[62:31]))
    else $error("word product wrong");
  word_sat_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_WORD_FRAC_MUL_SAT && w_both_min |=> gpr_data == Q31_MAX)
    else $error("word saturation missing");
  round_val_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_WORD_FRAC_MUL_ROUND && src_one == 32'h40000000
    && src_two == 32'h00000001 |=> gpr_data == 32'h00000001)
    else $error("rounding wrong");
  round_sat_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_WORD_FRAC_MUL_ROUND && w_both_min |=> gpr_data == Q31_MAX)
    else $error("round saturation missing");
  diff_acc_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_HALF_DIFF_ACC |=> acc_we && acc_data == $past(acc_cur) + $past(h_diff))
    else $error("difference accumulate wrong");
  acc_target_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && is_acc_op |=> acc_ix == $past(acc_sel) ##1 acc_reg[acc_ix] == acc_data || acc_we)
    else $error("accumulator target wrong");
  mirror_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_LOW_HALF_MIRROR && src_two == 32'h00000001 |=> gpr_data == 32'h00008000)
    else $error("mirror wrong");
  repl_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_BYTE_REPL_REG |=> gpr_data == {4{$past(src_two[7:0])}})
    else $error("byte replicate wrong");
  half_lit_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_HALF_REPL_LIT && imm == 10'h200 |=> gpr_data == 32'hFE00FE00)
    else $error("half replicate wrong");
  insert_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_FIELD_INSERT_CTRL && ctrl_word[14:10] == 5'h04
    && ctrl_word[20:16] == 5'h04 && src_one == 32'h0000000F && src_two == 32'h00000000
    |=> gpr_data == 32'h000000F0)
    else $error("field insert wrong");
  // Write-back steps: an accumulator issue must land in the indexed slot next cycle
  sequence acc_issue_s;
    issue && is_acc_op;
  endsequence
  sequence acc_written_s;
    acc_we && !gpr_we && acc_ix == $past(acc_sel) && acc_reg[acc_ix] == acc_data;
  endsequence
  acc_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    acc_issue_s |=> acc_written_s)
    else $error("accumulator write lost");
  reg_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && is_reg_op |=> gpr_we && !acc_we && gpr_ix == $past(dest_ix))
    else $error("register answer missing");
  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    !issue |=> !gpr_we && !acc_we)
    else $error("strobe without issue");
  mirror_upper_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_LOW_HALF_MIRROR |=> gpr_data[WORD_W-1:HALF_W] == 16'h0000)
    else $error("mirror upper half not zero");
  byte_lit_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_BYTE_REPL_LIT |=> gpr_data == {4{$past(imm[BYTE_W-1:0])}})
    else $error("byte literal replicate wrong");
  half_reg_a: assert property (@(posedge clk_sys) disable iff (rst)
    issue && op == OP_HALF_REPL_REG |=> gpr_data == {2{$past(src_two[HALF_W-1:0])}})
    else $error("halfword replicate wrong");
endmodule

// >>> verification/host_pipe_model.sv
`timescale 1ns/1ps
module host_pipe_model
  import dsp_ext_pkg::*;
(
  input  wire logic           clk_sys,   // Core clock
  output logic                issue,     // Operation valid
  output dsp_op_t             op,        // Decoded operation
  output logic [31:0]         src_one,   // First source word
  output logic [31:0]         src_two,   // Second source word
  output logic [IMM_W-1:0]    imm,       // Immediate
  output logic [ACC_IX_W-1:0] acc_sel,   // Accumulator index
  output logic [4:0]          dest_ix,   // Destination index
  output logic [31:0]         ctrl_word  // Control word
);
  initial begin
    {issue, src_one, src_two, imm, acc_sel, dest_ix, ctrl_word} = '0;
    op = OP_SIGNED_PRODUCT;
  end
  // Whole operand set with every issue; no stall, results always taken
  task automatic send(input dsp_op_t o, input logic [31:0] a, input logic [31:0] b,
                      input logic [IMM_W-1:0] i, input logic [ACC_IX_W-1:0] s,
                      input logic [4:0] d, input logic [31:0] c);
    @(posedge clk_sys);
    {issue, op, src_one, src_two, imm, acc_sel, dest_ix, ctrl_word} <= {1'b1, o, a, b, i, s, d, c};
  endtask
  // Stale operands inverted so an idle bus never matches a live one
  task automatic idle();
    @(posedge clk_sys);
    issue <= 1'b0;
    {src_one, src_two} <= ~{src_one, src_two};
  endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import dsp_ext_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic issue, gpr_we, acc_we;
  dsp_op_t op;
  logic [31:0] src_one, src_two, ctrl_word, gpr_data;
  logic [IMM_W-1:0] imm;
  logic [ACC_IX_W-1:0] acc_sel, acc_ix;
  logic [4:0] dest_ix, gpr_ix;
  logic [ACC_W-1:0] acc_data;
  logic [63:0] acc_m [4] = '{default: 64'h0000000000000000};
  int bad_count = 0;
  int n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  host_pipe_model host (.clk_sys(clk_sys), .issue(issue), .op(op), .src_one(src_one),
    .src_two(src_two), .imm(imm), .acc_sel(acc_sel), .dest_ix(dest_ix), .ctrl_word(ctrl_word));
  dsp_fraction_multiply_bit_ops DUT (.clk_sys(clk_sys), .rst(rst), .issue(issue), .op(op),
    .src_one(src_one), .src_two(src_two), .imm(imm), .acc_sel(acc_sel), .dest_ix(dest_ix),
    .ctrl_word(ctrl_word), .gpr_we(gpr_we), .gpr_ix(gpr_ix), .gpr_data(gpr_data),
    .acc_we(acc_we), .acc_ix(acc_ix), .acc_data(acc_data));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] fq15(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return (a == Q15_MIN && b == Q15_MIN) ? Q15_MAX : p[30:15];
  endfunction
  function automatic logic [31:0] fq31(input logic [31:0] a, input logic [31:0] b, input logic r);
    logic signed [63:0] p;
    p = ($signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b})) <<< 1;
    if (r) p = p + 64'h0000000080000000;
    return (a == Q31_MIN && b == Q31_MIN) ? Q31_MAX : p[63:32];
  endfunction
  task automatic do_gpr(input dsp_op_t o, input logic [31:0] a, input logic [31:0] b,
                        input logic [IMM_W-1:0] i, input logic [31:0] c, input logic [31:0] e);
    host.send(o, a, b, i, 2'h0, 5'h11, c);
    host.idle();
    #1;
    check(64'(gpr_we), 64'h1);
    check(64'({acc_we, gpr_ix}), 64'h11);
    check(64'(gpr_data), 64'(e));
    @(posedge clk_sys) #1;
    check(64'(gpr_we), 64'h0);
  endtask
  task automatic t_reset();
    check(64'({gpr_we, acc_we, gpr_ix, acc_ix, gpr_data}), 64'h0);
    check(acc_data, 64'h0);
  endtask
  task automatic t_frac();
    logic [31:0] a [5] = '{32'h80000000, 32'h40008000, 32'h40000001, 32'hC0007FFF, 32'h40000000};
    logic [31:0] b [5] = '{32'h80000000, 32'h40008000, 32'hC0000003, 32'h80000000, 32'h00000001};
    for (int k = 0; k < 5; k++) begin
      do_gpr(OP_PAIR_FRAC_MUL_SAT, a[k], b[k], 10'h000, 32'h0,
             {fq15(a[k][31:16], b[k][31:16]), fq15(a[k][15:0], b[k][15:0])});
      do_gpr(OP_WORD_FRAC_MUL_SAT, a[k], b[k], 10'h000, 32'h0, fq31(a[k], b[k], 1'b0));
      do_gpr(OP_WORD_FRAC_MUL_ROUND, a[k], b[k], 10'h000, 32'h0, fq31(a[k], b[k], 1'b1));
    end
  endtask
  task automatic t_bits();
    logic [4:0] sz [4] = '{5'h08, 5'h00, 5'h05, 5'h1F};
    logic [4:0] ps [4] = '{5'h04, 5'h03, 5'h1E, 5'h01};
    logic [31:0] m;
    do_gpr(OP_LOW_HALF_MIRROR, 32'hFFFF1235, 32'hFFFF1235, 10'h000, 32'h0, 32'h0000AC48);
    do_gpr(OP_LOW_HALF_MIRROR, 32'h0, 32'h00000001, 10'h000, 32'h0, 32'h00008000);
    for (int k = 0; k < 4; k++) begin
      m = ((32'h00000001 << sz[k]) - 32'h00000001) << ps[k];
      do_gpr(OP_FIELD_INSERT_CTRL, 32'h9ABCDEF5, 32'h13572468, 10'h000,
             {11'h0, ps[k], 1'b0, sz[k], 10'h000},
             (32'h13572468 & ~m) | ((32'h9ABCDEF5 << ps[k]) & m));
    end
    do_gpr(OP_FIELD_INSERT_CTRL, 32'h0000000F, 32'h0, 10'h000,
           {11'h0, 5'h04, 1'b0, 5'h04, 10'h000}, 32'h000000F0);
    do_gpr(OP_BYTE_REPL_LIT, 32'h0, 32'h0, 10'h3A5, 32'h0, 32'hA5A5A5A5);
    do_gpr(OP_BYTE_REPL_REG, 32'h1234567E, 32'h1234567E, 10'h000, 32'h0, 32'h7E7E7E7E);
    do_gpr(OP_HALF_REPL_LIT, 32'h0, 32'h0, 10'h2C3, 32'h0, 32'hFEC3FEC3);
    do_gpr(OP_HALF_REPL_LIT, 32'h0, 32'h0, 10'h0C3, 32'h0, 32'h00C300C3);
    do_gpr(OP_HALF_REPL_LIT, 32'h0, 32'h0, 10'h200, 32'h0, 32'hFE00FE00);
    do_gpr(OP_HALF_REPL_REG, 32'h1234567E, 32'h1234567E, 10'h000, 32'h0, 32'h567E567E);
  endtask
  // Back-to-back pairs on each of the four accumulators: second op must see the first's result
  task automatic t_acc();
    dsp_op_t ops [8] = '{OP_SIGNED_PRODUCT, OP_SIGNED_MUL_ADD, OP_UNSIGNED_PRODUCT,
      OP_UNSIGNED_MUL_ADD, OP_SIGNED_MUL_SUB, OP_UNSIGNED_MUL_SUB, OP_HALF_DIFF_ACC,
      OP_HALF_DIFF_ACC};
    logic [31:0] a, b;
    logic [1:0] s, ps;
    logic signed [63:0] sp, up, hd;
    for (int k = 0; k <= 8; k++) begin
      if (k < 8) begin
        a = 32'hF0007FF3 + k;
        b = 32'h8001FFFE - k;
        s = 2'(k >> 1);
        sp = $signed(a) * $signed(b);
        up = a * b;
        hd = $signed(a[31:16]) * $signed(b[31:16]) - $signed(a[15:0]) * $signed(b[15:0]);
        host.send(ops[k], a, b, 10'h000, s, 5'h00, 32'h0);
      end else host.idle();
      #1;
      if (k > 0) begin
        check(64'({acc_we, acc_ix}), 64'({1'b1, ps}));
        check(acc_data, acc_m[ps]);
      end
      if (k < 8) begin
        case (ops[k])
          OP_SIGNED_PRODUCT:   acc_m[s] = sp;
          OP_SIGNED_MUL_ADD:   acc_m[s] = acc_m[s] + sp;
          OP_UNSIGNED_PRODUCT: acc_m[s] = up;
          OP_UNSIGNED_MUL_ADD: acc_m[s] = acc_m[s] + up;
          OP_SIGNED_MUL_SUB:   acc_m[s] = acc_m[s] - sp;
          OP_UNSIGNED_MUL_SUB: acc_m[s] = acc_m[s] - up;
          default:             acc_m[s] = acc_m[s] + hd;
        endcase
        ps = s;
      end
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys) #1;
    t_reset();
    t_frac();
    t_bits();
    t_acc();
    end_of_test();
  end
endmodule
